// >>> design/area_info_responder_consts.vh
`ifndef AREA_INFO_RESPONDER_CONSTS_VH
`define AREA_INFO_RESPONDER_CONSTS_VH

// Framing bytes.
`define COMMAND_START_BYTE 8'h01
`define REPLY_START_BYTE 8'h81
`define FRAME_END_BYTE 8'h03
`define LENGTH_HIGH_REPLY 8'h00

// Command and reply codes.
`define CMD_SIGNATURE 8'h3A
`define CMD_AREA_INFO 8'h3B
`define REPLY_SIG_ERR 8'hBA
`define REPLY_AREA_ERR 8'hBB

// Length fields.
`define LEN_SIG_CMD 16'h0001
`define LEN_AREA_CMD 16'h0002
`define LEN_MAX_CMD 16'h0101
`define LEN_SIG_REPLY 8'h2A
`define LEN_AREA_REPLY 8'h1A
`define LEN_ERR_REPLY 8'h0A

// Status codes of error replies.
`define STS_PACKET_ERR 8'hC1
`define STS_CHECKSUM_ERR 8'hC2
`define STS_PARAM_ERR 8'hC3

// Filler for status detail and failure address.
`define UNUSED_CODE_BYTE 8'hFF

// Frame layout: positions of fixed bytes and payload.
`define POS_LEN_HIGH 8'h01
`define POS_LEN_LOW 8'h02
`define POS_REPLY_CODE 8'h03
`define POS_PAYLOAD 8'h04
`define POS_SUM_OFFSET 8'h03
`define POS_END_OFFSET 8'h04
`define PAYLOAD_AREA_COUNT 8'h04
`define AREA_WORD_LAST 8'h17

`endif

// >>> design/area_info_responder.v
`timescale 1ns/1ps
`include "area_info_responder_consts.vh"

module area_info_responder (
  input wire i_clk_sys,             // System clock, 25 MHz
  input wire i_rst_b,               // Synchronous reset, active low
  input wire [7:0] i_rx_data,       // Received command byte
  input wire i_rx_valid,            // Received byte present
  output reg o_rx_ready,            // Block accepts a received byte
  output reg [7:0] o_tx_data,       // Reply byte to the link
  output reg o_tx_valid,            // Reply byte present
  input wire i_tx_ready,            // Link takes the reply byte
  input wire [7:0] i_area_count,    // Count of accessible areas
  output reg [7:0] o_area_sel,      // Area number whose descriptor is read
  input wire [3:0] i_area_class,    // Class of selected area
  input wire [3:0] i_area_index,    // Index of selected area within its class
  input wire [31:0] i_area_start,   // Start address of selected area
  input wire [31:0] i_area_end,     // End address of selected area
  input wire [31:0] i_erase_unit,   // Erase unit size, zero when unavailable
  input wire [31:0] i_write_unit,   // Write unit size, zero when unavailable
  input wire [31:0] i_read_unit,    // Read unit size, zero when unavailable
  input wire [31:0] i_crc_unit,     // CRC unit size, zero when unavailable
  output reg [7:0] o_reply_index,   // Frame position of the reply byte being built
  input wire [7:0] i_sig_byte       // Signature reply byte at o_reply_index
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LNH = 3'h1;
  localparam [2:0] ST_LNL = 3'h2;
  localparam [2:0] ST_BODY = 3'h3;
  localparam [2:0] ST_SUM = 3'h4;
  localparam [2:0] ST_END = 3'h5;
  localparam [2:0] ST_SEND = 3'h6;

  localparam [1:0] RK_ERR = 2'h0;
  localparam [1:0] RK_SIG = 2'h1;
  localparam [1:0] RK_AREA = 2'h2;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] len_reg;
  reg [15:0] len_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [7:0] rx_sum_reg;
  reg [7:0] rx_sum_next;
  reg [7:0] cmd_reg;
  reg [7:0] cmd_next;
  reg [7:0] num_reg;
  reg [7:0] num_next;
  reg [1:0] kind_reg;
  reg [1:0] kind_next;
  reg [7:0] res_reg;
  reg [7:0] res_next;
  reg [7:0] sts_reg;
  reg [7:0] sts_next;
  reg [7:0] rlen_reg;
  reg [7:0] rlen_next;
  reg [7:0] idx_next;
  reg [7:0] tx_sum_reg;
  reg [7:0] tx_sum_next;
  reg [7:0] area_sel_next;

  // Two-entry reply buffer: head drives the link, skid absorbs one stalled byte.
  reg [7:0] skid_data_reg;
  reg skid_valid_reg;

  wire rx_take = i_rx_valid & o_rx_ready;
  wire buf_ready = ~skid_valid_reg;
  wire push = (state_reg == ST_SEND) & buf_ready;
  wire pop = o_tx_valid & i_tx_ready;
  wire [15:0] body_left = cnt_reg - 16'h0001;

  reg [7:0] frame_byte;
  reg [7:0] pay;
  reg [7:0] word_byte;
  wire [191:0] area_words = {i_area_start, i_area_end, i_erase_unit, i_write_unit, i_read_unit, i_crc_unit};

  // Reply byte at the current frame position.
  always @*
  begin
    pay = o_reply_index - `POS_PAYLOAD;
    word_byte = pay - 8'h01;
    frame_byte = `UNUSED_CODE_BYTE;
    if (o_reply_index == 8'h00)
      frame_byte = `REPLY_START_BYTE;
    else if (o_reply_index == `POS_LEN_HIGH)
      frame_byte = `LENGTH_HIGH_REPLY;
    else if (o_reply_index == `POS_LEN_LOW)
      frame_byte = rlen_reg;
    else if (o_reply_index == `POS_REPLY_CODE)
      frame_byte = res_reg;
    else if (o_reply_index == rlen_reg + `POS_SUM_OFFSET)
      frame_byte = 8'h00 - tx_sum_reg;
    else if (o_reply_index == rlen_reg + `POS_END_OFFSET)
      frame_byte = `FRAME_END_BYTE;
    else
    begin
      case (kind_reg)
        RK_ERR:
          if (pay == 8'h00)
            frame_byte = sts_reg;
        RK_AREA:
          if (pay == 8'h00)
            frame_byte = {i_area_class, i_area_index};
          else if (word_byte <= `AREA_WORD_LAST)
            frame_byte = area_words[191 - {word_byte, 3'h0} -: 8];
        RK_SIG:
          if (pay == `PAYLOAD_AREA_COUNT)
            frame_byte = i_area_count;
          else
            frame_byte = i_sig_byte;
        default:
          frame_byte = `UNUSED_CODE_BYTE;
      endcase
    end
  end

  // Decide the reply once the end byte position is reached.
  // The area count comes in as an argument so that a change of it wakes the calling process.
  task decide;
    input end_ok;
    input [7:0] area_count;
    begin
      rlen_next = `LEN_ERR_REPLY;
      kind_next = RK_ERR;
      res_next = (cmd_reg == `CMD_SIGNATURE) ? `REPLY_SIG_ERR : `REPLY_AREA_ERR;
      if (!end_ok)
        sts_next = `STS_PACKET_ERR;
      else if (rx_sum_reg != 8'h00)
        sts_next = `STS_CHECKSUM_ERR;
      else if (len_reg == 16'h0000 || len_reg > `LEN_MAX_CMD)
        sts_next = `STS_PACKET_ERR;
      else if ((cmd_reg == `CMD_SIGNATURE && len_reg != `LEN_SIG_CMD) ||
               (cmd_reg == `CMD_AREA_INFO && len_reg != `LEN_AREA_CMD))
        sts_next = `STS_PACKET_ERR;
      else if (cmd_reg == `CMD_AREA_INFO && num_reg >= area_count)
        sts_next = `STS_PARAM_ERR;
      else if (cmd_reg == `CMD_SIGNATURE)
      begin
        kind_next = RK_SIG;
        res_next = `CMD_SIGNATURE;
        rlen_next = `LEN_SIG_REPLY;
      end
      else
      begin
        kind_next = RK_AREA;
        res_next = `CMD_AREA_INFO;
        rlen_next = `LEN_AREA_REPLY;
        area_sel_next = num_reg;
      end
      // Commands other than these two belong to other handlers, so no reply here.
      if (cmd_reg == `CMD_SIGNATURE || cmd_reg == `CMD_AREA_INFO)
        state_next = ST_SEND;
      else
        state_next = ST_IDLE;
    end
  endtask

  always @*
  begin
    state_next = state_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    rx_sum_next = rx_sum_reg;
    cmd_next = cmd_reg;
    num_next = num_reg;
    kind_next = kind_reg;
    res_next = res_reg;
    sts_next = sts_reg;
    rlen_next = rlen_reg;
    idx_next = o_reply_index;
    tx_sum_next = tx_sum_reg;
    area_sel_next = o_area_sel;
    case (state_reg)
      ST_IDLE:
        if (rx_take && i_rx_data == `COMMAND_START_BYTE)
        begin
          state_next = ST_LNH;
          rx_sum_next = 8'h00;
          cmd_next = 8'h00;
          num_next = 8'h00;
        end
      ST_LNH:
        if (rx_take)
        begin
          len_next = {i_rx_data, len_reg[7:0]};
          rx_sum_next = rx_sum_reg + i_rx_data;
          state_next = ST_LNL;
        end
      ST_LNL:
        if (rx_take)
        begin
          len_next = {len_reg[15:8], i_rx_data};
          cnt_next = {len_reg[15:8], i_rx_data};
          rx_sum_next = rx_sum_reg + i_rx_data;
          state_next = ({len_reg[15:8], i_rx_data} == 16'h0000) ? ST_SUM : ST_BODY;
        end
      ST_BODY:
        if (rx_take)
        begin
          // Any length is walked byte by byte so the end byte is found where the host put it.
          if (cnt_reg == len_reg)
            cmd_next = i_rx_data;
          else if (cnt_reg == len_reg - 16'h0001)
            num_next = i_rx_data;
          rx_sum_next = rx_sum_reg + i_rx_data;
          cnt_next = body_left;
          if (body_left == 16'h0000)
            state_next = ST_SUM;
        end
      ST_SUM:
        if (rx_take)
        begin
          rx_sum_next = rx_sum_reg + i_rx_data;
          state_next = ST_END;
        end
      ST_END:
        if (rx_take)
        begin
          decide(i_rx_data == `FRAME_END_BYTE, i_area_count);
          idx_next = 8'h00;
          tx_sum_next = 8'h00;
        end
      ST_SEND:
        if (push)
        begin
          if (o_reply_index >= `POS_LEN_HIGH && o_reply_index < rlen_reg + `POS_SUM_OFFSET)
            tx_sum_next = tx_sum_reg + frame_byte;
          idx_next = o_reply_index + 8'h01;
          if (o_reply_index == rlen_reg + `POS_END_OFFSET)
            state_next = ST_IDLE;
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_IDLE;
      len_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      rx_sum_reg <= 8'h00;
      cmd_reg <= 8'h00;
      num_reg <= 8'h00;
      kind_reg <= RK_ERR;
      res_reg <= 8'h00;
      sts_reg <= 8'h00;
      rlen_reg <= 8'h00;
      tx_sum_reg <= 8'h00;
      o_reply_index <= 8'h00;
      o_area_sel <= 8'h00;
      o_rx_ready <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      rx_sum_reg <= rx_sum_next;
      cmd_reg <= cmd_next;
      num_reg <= num_next;
      kind_reg <= kind_next;
      res_reg <= res_next;
      sts_reg <= sts_next;
      rlen_reg <= rlen_next;
      tx_sum_reg <= tx_sum_next;
      o_reply_index <= idx_next;
      o_area_sel <= area_sel_next;
      // Reception pauses until the reply end byte enters the buffer; the host waits for replies anyway.
      o_rx_ready <= (state_next != ST_SEND);
    end
  end

  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_tx_data <= 8'h00;
      o_tx_valid <= 1'b0;
      skid_data_reg <= 8'h00;
      skid_valid_reg <= 1'b0;
    end
    else if (!o_tx_valid || pop)
    begin
      if (skid_valid_reg)
      begin
        o_tx_data <= skid_data_reg;
        o_tx_valid <= 1'b1;
        skid_valid_reg <= 1'b0;
      end
      else
      begin
        o_tx_data <= frame_byte;
        o_tx_valid <= push;
      end
    end
    else if (push)
    begin
      skid_data_reg <= frame_byte;
      skid_valid_reg <= 1'b1;
    end
  end

endmodule // area_info_responder

// >>> verification/area_info_responder_checker.sv
`timescale 1ns/1ps
module area_info_responder_checker (
  input wire i_clk_sys, // System clock
  input wire i_rst_b, // Reset, active low
  input wire [7:0] o_tx_data, // Reply byte
  input wire o_tx_valid, // Reply byte present
  input wire i_tx_ready // Link takes reply byte
);
  reg [7:0] pos_reg;
  reg [7:0] len_reg;
  reg [7:0] sum_reg;
  wire tk = o_tx_valid && i_tx_ready;
  // Positions advance on taken bytes only, so a stalled link never shifts them.
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b || (tk && pos_reg == len_reg + 8'h04))
    begin
      pos_reg <= 8'h00;
      sum_reg <= 8'h00;
    end
    else if (tk)
    begin
      pos_reg <= pos_reg + 8'h01;
      sum_reg <= (pos_reg == 8'h00) ? 8'h00 : sum_reg + o_tx_data;
    end
  end
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
      len_reg <= 8'h00;
    else if (tk && pos_reg == 8'h02)
      len_reg <= o_tx_data;
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  start_byte_a: assert property (tk && pos_reg == 8'h00 |-> o_tx_data == 8'h81)
    else $error("reply start byte wrong");
  len_high_a: assert property (tk && pos_reg == 8'h01 |-> o_tx_data == 8'h00)
    else $error("reply length high wrong");
  len_legal_a: assert property (tk && pos_reg == 8'h02 |-> o_tx_data inside {8'h0A, 8'h1A, 8'h2A})
    else $error("reply length low wrong");
  err_code_a: assert property (tk && pos_reg == 8'h03 && len_reg == 8'h0A |-> o_tx_data inside {8'hBA, 8'hBB})
    else $error("error reply code wrong");
  area_code_a: assert property (tk && pos_reg == 8'h03 && len_reg == 8'h1A |-> o_tx_data == 8'h3B)
    else $error("area reply code wrong");
  filler_bytes_a: assert property (tk && len_reg == 8'h0A && pos_reg >= 8'h05 && pos_reg <= 8'h0C
    |-> o_tx_data == 8'hFF)
    else $error("error filler byte wrong");
  sum_zero_a: assert property (tk && pos_reg == len_reg + 8'h03 |-> sum_reg + o_tx_data == 8'h00)
    else $error("reply checksum wrong");
  end_byte_a: assert property (tk && pos_reg == len_reg + 8'h04 |-> o_tx_data == 8'h03)
    else $error("reply end byte wrong");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped while stalled");
  cover property (tk && pos_reg == 8'h03 && o_tx_data == 8'h3A);
  cover property (tk && pos_reg == 8'h03 && o_tx_data == 8'h3B);
  cover property (tk && pos_reg == 8'h03 && o_tx_data == 8'hBA);
  cover property (tk && pos_reg == 8'h03 && o_tx_data == 8'hBB);
endmodule // area_info_responder_checker

bind area_info_responder area_info_responder_checker chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready));

// >>> verification/host_tool_model.sv
`timescale 1ns/1ps
module host_tool_model (
  input wire i_clk_sys, // System clock
  input wire i_cmd_ready, // Block takes command byte
  input wire [7:0] i_reply_data, // Reply byte
  input wire i_reply_valid, // Reply byte present
  output logic [7:0] o_cmd_data = 8'h00, // Command byte
  output logic o_cmd_valid = 1'b0, // Command byte present
  output logic o_link_ready = 1'b0 // Host takes reply byte
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic slow = 1'b0;
  logic [1:0] tick_reg = 2'h0;
  always @(posedge i_clk_sys)
  begin
    tick_reg <= tick_reg + 2'h1;
    if (i_reply_valid && o_link_ready)
      got_q.push_back(i_reply_data);
    // A slow host takes one byte in four, which backs replies up into the buffer.
    o_link_ready <= !slow || tick_reg == 2'h3;
    if (o_cmd_valid && i_cmd_ready)
      void'(send_q.pop_front());
    o_cmd_valid <= send_q.size() > 0;
    // An idle data line toggles so that no stale byte looks valid.
    o_cmd_data <= (send_q.size() > 0) ? send_q[0] : ~o_cmd_data;
  end
endmodule // host_tool_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] area_cnt = 8'h03;
  wire [7:0] rx_data, tx_data, area_sel, reply_index;
  wire rx_valid, rx_ready, tx_valid, tx_ready;
  wire [31:0] erase_w;
  int error_cnt = 0;
  int num_checks = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] word(input logic [7:0] k, input logic [7:0] n);
    return {8'h80 | k, n, 8'h3C, k};
  endfunction
  assign erase_w = (area_sel == 8'h02) ? 32'h00000000 : word(8'h02, area_sel);
  area_info_responder dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .i_area_count(area_cnt), .o_area_sel(area_sel),
    .i_area_class({2'b00, area_sel[1:0]}), .i_area_index(area_sel[3:0] ^ 4'hF),
    .i_area_start(word(8'h00, area_sel)), .i_area_end(word(8'h01, area_sel)), .i_erase_unit(erase_w),
    .i_write_unit(word(8'h03, area_sel)), .i_read_unit(word(8'h04, area_sel)),
    .i_crc_unit(word(8'h05, area_sel)), .o_reply_index(reply_index), .i_sig_byte(reply_index ^ 8'hA5));
  host_tool_model host (.i_clk_sys(i_clk_sys), .i_cmd_ready(rx_ready), .i_reply_data(tx_data),
    .i_reply_valid(tx_valid), .o_cmd_data(rx_data), .o_cmd_valid(rx_valid), .o_link_ready(tx_ready));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic send_cmd(input logic [15:0] len, input logic [7:0] body[$], input logic [7:0] adj,
    input logic [7:0] fin);
    logic [7:0] s;
    s = 8'h00 - len[15:8] - len[7:0];
    foreach (body[i])
      s = s - body[i];
    @(negedge i_clk_sys);
    host.send_q = {host.send_q, 8'h01, len[15:8], len[7:0], body, s + adj, fin};
  endtask
  task automatic expect_reply(input string name, input logic [7:0] code, input logic [7:0] pay[$]);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    e = {8'h81, 8'h00, 8'(pay.size() + 1), code, pay};
    s = 8'h00;
    for (n = 1; n < e.size(); n++)
      s = s - e[n];
    e = {e, s, 8'h03};
    n = 0;
    while (host.got_q.size() < e.size() && n < 3000)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    if (host.got_q.size() < e.size())
    begin
      error_cnt++;
      $display("[ERR] %s expected full reply seen %0d bytes", name, host.got_q.size());
      summarize();
    end
    else
      foreach (e[i])
        check(name, host.got_q.pop_front(), e[i]);
  endtask
  task automatic err(input string name, input logic [7:0] code, input logic [7:0] sts);
    expect_reply(name, code, {sts, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
  endtask
  task automatic t_signature;
    logic [7:0] p[$];
    logic [7:0] i;
    @(negedge i_clk_sys);
    host.send_q = {8'h55, 8'h03, 8'h3A};
    send_cmd(16'h0001, {8'h3A}, 8'h00, 8'h03);
    for (i = 8'h04; i < 8'h2D; i++)
      p.push_back(i == 8'h08 ? area_cnt : i ^ 8'hA5);
    expect_reply("signature", 8'h3A, p);
  endtask
  task automatic t_errors;
    logic [7:0] big[$];
    send_cmd(16'h0002, {8'h3B, 8'h00}, 8'h01, 8'h05);
    err("end byte", 8'hBB, 8'hC1);
    send_cmd(16'h0002, {8'h3B, 8'h00}, 8'h01, 8'h03);
    err("checksum", 8'hBB, 8'hC2);
    send_cmd(16'h0001, {8'h3A}, 8'h10, 8'h03);
    err("sig checksum", 8'hBA, 8'hC2);
    send_cmd(16'h0002, {8'h3A, 8'h00}, 8'h00, 8'h03);
    err("sig length", 8'hBA, 8'hC1);
    send_cmd(16'h0001, {8'h3B}, 8'h00, 8'h03);
    err("area length", 8'hBB, 8'hC1);
    big = {8'h3B};
    repeat (257) big.push_back(8'h00);
    send_cmd(16'h0102, big, 8'h00, 8'h03);
    err("format length", 8'hBB, 8'hC1);
    // An empty packet and a foreign command code belong to other handlers and must draw no reply.
    big.delete();
    send_cmd(16'h0000, big, 8'h00, 8'h03);
    send_cmd(16'h0001, {8'h00}, 8'h00, 8'h03);
    send_cmd(16'h0002, {8'h3B, 8'h03}, 8'h00, 8'h03);
    err("area number", 8'hBB, 8'hC3);
    send_cmd(16'h0002, {8'h3B, 8'h07}, 8'h02, 8'h03);
    err("priority", 8'hBB, 8'hC2);
  endtask
  task automatic t_areas;
    logic [7:0] p[$];
    logic [7:0] n;
    logic [7:0] k;
    logic [31:0] w;
    @(negedge i_clk_sys);
    host.slow = 1'b1;
    // Three requests queued back to back while the host stalls, so the buffer fills.
    for (n = 8'h00; n < 8'h03; n++)
      send_cmd(16'h0002, {8'h3B, n}, 8'h00, 8'h03);
    for (n = 8'h00; n < 8'h03; n++)
    begin
      p.delete();
      p.push_back({n[3:0], ~n[3:0]});
      for (k = 8'h00; k < 8'h06; k++)
      begin
        w = (k == 8'h02 && n == 8'h02) ? 32'h00000000 : word(k, n);
        p = {p, w[31:24], w[23:16], w[15:8], w[7:0]};
      end
      expect_reply("area reply", 8'h3B, p);
    end
    host.slow = 1'b0;
  endtask
  initial
  begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("tx valid", {7'h00, tx_valid}, 8'h00);
    check("rx ready", {7'h00, rx_ready}, 8'h01);
    t_signature();
    t_errors();
    t_areas();
    check("spare bytes", 8'(host.got_q.size()), 8'h00);
    summarize();
  end
endmodule // testbench
